/* bfs_top.sv */
// battery fault supervisor: error codes 10 to 16 and overcurrent warning
`timescale 1ns/1ps
`default_nettype none
`include "bfs_cfg.svh"
module bfs_top #(
    parameter int unsigned MEAS_CYC  = `BFS_MEAS_CYCLE_CYC,
    parameter int unsigned BLINK_CYC = `BFS_BLINK_CYC,
    parameter int unsigned GAP_CYC   = `BFS_GAP_CYC
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    // measurements
    input  wire bfs_pkg::bfs_mv_t   cell_v_max_mv,
    input  wire bfs_pkg::bfs_mv_t   cell_v_min_mv,
    input  wire bfs_pkg::bfs_scur_t pack_current,
    input  wire logic               relay_open_cmd,
    input  wire logic               current_meas_en,
    // health reports
    input  wire logic               startup_active,
    input  wire logic               settings_io_broken,
    input  wire logic               startup_fuse_fault,
    input  wire logic               startup_balance_fault,
    input  wire logic               internal_bus_fail,
    // pack control
    output var  logic               charge_en,
    output var  logic               discharge_en,
    output var  logic               opto_relay_on,
    output var  logic               charge_opto_on,
    output var  bfs_pkg::bfs_cur_t  chg_limit_report,
    output var  bfs_pkg::bfs_cur_t  dis_limit_report,
    output var  logic               settings_restore,
    // indication
    output var  logic               error_led,
    output var  logic               irq
);
    import bfs_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    bfs_cur_t    shunt_max_q;
    bfs_cur_t    charge_current_trip_limit_q;
    bfs_cur_t    discharge_current_trip_limit_q;
    bfs_cur_t    charge_current_nominal_limit_q;
    bfs_cur_t    discharge_current_nominal_limit_q;
    logic [3:0]  cell_chemistry_select_q;
    logic [7:0]  int_stat_q;
    logic [7:0]  int_mask_q;
    logic [7:0]  act_q;
    logic [7:0]  act_prev_q;
    bfs_phase_t  phase_q;
    bfs_code_t   code_q;
    logic [31:0] tick_cnt_q;
    logic        tick_q;
    logic        restore_q;

    logic        wr_en;
    logic        rd_map;
    logic [31:0] rd_d;
    logic [7:0]  cond;
    logic [7:0]  rise;
    bfs_code_t   code_d;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // bus outputs staged in setup, so all come from flip-flops
    assign wr_en = psel & penable & pready & pwrite;

    always_comb begin
        rd_map = 1'b1;
        rd_d   = 32'h0;
        unique case (paddr)
            `BFS_A_SHUNT_MAX: rd_d = {16'h0, shunt_max_q};
            `BFS_A_CHG_TRIP:  rd_d = {16'h0, charge_current_trip_limit_q};
            `BFS_A_DIS_TRIP:  rd_d = {16'h0, discharge_current_trip_limit_q};
            `BFS_A_CHG_NOM:   rd_d = {16'h0, charge_current_nominal_limit_q};
            `BFS_A_DIS_NOM:   rd_d = {16'h0, discharge_current_nominal_limit_q};
            `BFS_A_CELL_CHEMISTRY_SELECT:      rd_d = {28'h0, cell_chemistry_select_q};
            `BFS_A_STATUS:    rd_d = {14'h0, phase_q, 3'h0, code_q, act_q};
            `BFS_A_INT_STAT:  rd_d = {24'h0, int_stat_q};
            `BFS_A_INT_MASK:  rd_d = {24'h0, int_mask_q};
            default:          rd_map = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_map;
            if (psel & ~penable) begin
                prdata <= pwrite ? 32'h0 : rd_d;
            end
        end
    end

    // settings; restore reloads defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shunt_max_q                       <= `BFS_RST_SHUNT_MAX;
            charge_current_trip_limit_q       <= `BFS_RST_CHG_TRIP;
            discharge_current_trip_limit_q    <= `BFS_RST_DIS_TRIP;
            charge_current_nominal_limit_q    <= `BFS_RST_CHG_NOM;
            discharge_current_nominal_limit_q <= `BFS_RST_DIS_NOM;
            cell_chemistry_select_q           <= `BFS_RST_CELL_CHEMISTRY_SELECT;
        end else if (restore_q) begin
            shunt_max_q                       <= `BFS_RST_SHUNT_MAX;
            charge_current_trip_limit_q       <= `BFS_RST_CHG_TRIP;
            discharge_current_trip_limit_q    <= `BFS_RST_DIS_TRIP;
            charge_current_nominal_limit_q    <= `BFS_RST_CHG_NOM;
            discharge_current_nominal_limit_q <= `BFS_RST_DIS_NOM;
            cell_chemistry_select_q           <= `BFS_RST_CELL_CHEMISTRY_SELECT;
        end else if (wr_en) begin
            unique case (paddr)
                `BFS_A_SHUNT_MAX: shunt_max_q                       <= pwdata[15:0];
                `BFS_A_CHG_TRIP:  charge_current_trip_limit_q       <= pwdata[15:0];
                `BFS_A_DIS_TRIP:  discharge_current_trip_limit_q    <= pwdata[15:0];
                `BFS_A_CHG_NOM:   charge_current_nominal_limit_q    <= pwdata[15:0];
                `BFS_A_DIS_NOM:   discharge_current_nominal_limit_q <= pwdata[15:0];
                `BFS_A_CELL_CHEMISTRY_SELECT:      cell_chemistry_select_q           <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    assign rise = act_q & ~act_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= 8'h0;
            int_mask_q <= `BFS_RST_INT_MASK;
            act_prev_q <= 8'h0;
            irq        <= 1'b0;
        end else begin
            act_prev_q <= act_q;
            // set wins over clear
            if (wr_en && paddr == `BFS_A_INT_STAT) begin
                int_stat_q <= (int_stat_q & ~pwdata[7:0]) | rise;
            end else begin
                int_stat_q <= int_stat_q | rise;
            end
            if (wr_en && paddr == `BFS_A_INT_MASK) begin
                int_mask_q <= pwdata[7:0];
            end
            irq <= |(int_stat_q & int_mask_q);
        end
    end

    // ----------------------------------------
    // tick and phase
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q >= MEAS_CYC - 1);
            tick_cnt_q <= (tick_cnt_q >= MEAS_CYC - 1) ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    // halt ends only at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= BFS_PH_POWERUP;
        end else if (act_q[6]) begin
            phase_q <= BFS_PH_HALT;
        end else if (tick_q && phase_q == BFS_PH_POWERUP) begin
            phase_q <= BFS_PH_RUN;
        end
    end

    // ----------------------------------------
    // raw conditions
    // ----------------------------------------
    logic [16:0] cur_abs;
    logic        cur_chg;
    logic [17:0] chg_warn_lvl;
    logic [17:0] dis_warn_lvl;

    assign cur_chg      = ~pack_current[15];
    assign cur_abs      = pack_current[15] ? 17'(-$signed({pack_current[15], pack_current}))
                                           : {1'b0, pack_current};
    // 1.2x as x + x/5, wide to avoid wrap
    assign chg_warn_lvl = {2'b0, charge_current_nominal_limit_q}
                        + 18'(charge_current_nominal_limit_q / 16'd5);
    assign dis_warn_lvl = {2'b0, discharge_current_nominal_limit_q}
                        + 18'(discharge_current_nominal_limit_q / 16'd5);

    always_comb begin
        // active: thresholds move inward
        if (act_q[0]) begin
            cond[0] = (cell_v_max_mv > `BFS_CELL_HIGH_MV - `BFS_CELL_HYST_MV)
                    | (cell_v_min_mv < `BFS_CELL_LOW_MV + `BFS_CELL_HYST_MV);
        end else begin
            cond[0] = (cell_v_max_mv > `BFS_CELL_HIGH_MV)
                    | (cell_v_min_mv < `BFS_CELL_LOW_MV);
        end
        cond[1] = relay_open_cmd & pack_current[15];
        cond[2] = ~current_meas_en
                | (cur_abs > {shunt_max_q, 1'b0})
                | (cur_chg & (cur_abs > {1'b0, charge_current_trip_limit_q}))
                | (~cur_chg & (cur_abs > {1'b0, discharge_current_trip_limit_q}));
        cond[3] = (cell_chemistry_select_q == 4'h0)
                | (cell_chemistry_select_q > `BFS_CELL_CHEMISTRY_SELECT_MAX);
        cond[4] = startup_active & settings_io_broken;
        cond[5] = startup_active & (startup_fuse_fault | startup_balance_fault);
        cond[6] = internal_bus_fail;
        cond[7] = current_meas_en
                & ((cur_chg & ({1'b0, cur_abs} > chg_warn_lvl))
                 | (~cur_chg & ({1'b0, cur_abs} > dis_warn_lvl)));
    end

    // ----------------------------------------
    // trigger and release
    // ----------------------------------------
    localparam logic [7:0] LONG_HOLD = `BFS_LONG_HOLD_MASK;
    localparam logic [7:0] LATCHED   = `BFS_LATCH_MASK;
    localparam logic [7:0] FAST      = `BFS_FAST_MASK;
    localparam logic [1:0] DEB_LAST  = 2'(`BFS_DEBOUNCE_TICKS - 1);
    localparam logic [3:0] HOLD_LAST = 4'(`BFS_ERR_HOLD_TICKS - 1);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_err
            logic [1:0] on_q;
            logic [3:0] off_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    on_q     <= 2'h0;
                    off_q    <= 4'h0;
                    act_q[gi] <= 1'b0;
                end else if (tick_q) begin
                    if (cond[gi]) begin
                        off_q <= 4'h0;
                        if (!act_q[gi]) begin
                            if (on_q >= DEB_LAST
                                || (FAST[gi] && phase_q == BFS_PH_POWERUP)) begin
                                act_q[gi] <= 1'b1;
                                on_q     <= 2'h0;
                            end else begin
                                on_q <= on_q + 2'h1;
                            end
                        end
                    end else begin
                        on_q <= 2'h0;
                        if (act_q[gi] && !LATCHED[gi]) begin
                            // long hold: 15 s down after fault
                            if (!LONG_HOLD[gi] || off_q >= HOLD_LAST) begin
                                act_q[gi] <= 1'b0;
                                off_q    <= 4'h0;
                            end else begin
                                off_q <= off_q + 4'h1;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        code_d = 5'h0;
        for (int i = 6; i >= 0; i--) begin
            if (act_q[i]) begin
                code_d = `BFS_CODE_BASE + 5'(i);
            end
        end
    end

    logic halt;
    logic all_off;
    assign halt    = (phase_q == BFS_PH_HALT);
    assign all_off = |(act_q[6:0] & `BFS_OFF_MASK) | halt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_en        <= 1'b0;
            discharge_en     <= 1'b0;
            opto_relay_on    <= 1'b0;
            charge_opto_on   <= 1'b0;
            chg_limit_report <= 16'h0;
            dis_limit_report <= 16'h0;
            code_q           <= 5'h0;
            restore_q        <= 1'b0;
            settings_restore <= 1'b0;
        end else begin
            charge_en      <= ~all_off;
            discharge_en   <= ~all_off;
            opto_relay_on  <= ~all_off;
            charge_opto_on <= ~all_off & ~|(act_q[6:0] & `BFS_COPTO_MASK);
            // warning trims report to 3/4
            chg_limit_report <= act_q[7] ? charge_current_nominal_limit_q
                                           - (charge_current_nominal_limit_q >> 2)
                                         : charge_current_nominal_limit_q;
            dis_limit_report <= act_q[7] ? discharge_current_nominal_limit_q
                                           - (discharge_current_nominal_limit_q >> 2)
                                         : discharge_current_nominal_limit_q;
            code_q           <= code_d;
            restore_q        <= rise[4];
            settings_restore <= rise[4];
        end
    end

    bfs_blink #(
        .BLINK_CYC (BLINK_CYC),
        .GAP_CYC   (GAP_CYC)
    ) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .code    (code_q),
        .led_q   (error_led)
    );
endmodule // bfs_top
`default_nettype wire

/* bfs_cfg.svh */
// constants and rule notes for the fault supervisor
// Notes on behaviour
// - cell above 4.5 V or below 0.8 V raises code 10
// - code 10: 15 s hold, 10 mV hysteresis, all off
// - relay open with negative current raises code 11, all off
// - metering off, over 2x shunt max or trip limits: code 12
// - code 12 keeps outputs off 15 s after it clears
// - bad or missing chemistry: code 13, charge opto off too
// - broken settings access at start-up: defaults, code 14, outputs on
// - start-up fuse or balancing fault: code 15, all off
// - bus failure: code 16, halt, all off
// - current over 1.2x nominal lowers reported limit, relay stays on
// - led blinks active code count then a long off gap
// - trigger after 3 consecutive 1.25 s cycles
// - after power-on code 10 triggers on the first measurement
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

// timing
`define BFS_CLK_MHZ         100
`define BFS_MEAS_CYCLE_MS   1250
`define BFS_MEAS_CYCLE_CYC  (`BFS_MEAS_CYCLE_MS * 1000 * `BFS_CLK_MHZ)
`define BFS_ERR_HOLD_MS     15000
`define BFS_ERR_HOLD_TICKS  ((`BFS_ERR_HOLD_MS + `BFS_MEAS_CYCLE_MS - 1) / `BFS_MEAS_CYCLE_MS)
`define BFS_DEBOUNCE_TICKS  3
`define BFS_BLINK_MS        250
`define BFS_BLINK_CYC       (`BFS_BLINK_MS * 1000 * `BFS_CLK_MHZ)
`define BFS_GAP_MS          2000
`define BFS_GAP_CYC         (`BFS_GAP_MS * 1000 * `BFS_CLK_MHZ)

// thresholds, millivolts
`define BFS_CELL_HIGH_MV    13'd4500
`define BFS_CELL_LOW_MV     13'd800
`define BFS_CELL_HYST_MV    13'd10

// bit i is code 10+i, bit 7 warning
`define BFS_CODE_BASE       5'd10
`define BFS_OFF_MASK        7'h6f
`define BFS_COPTO_MASK      7'h08
`define BFS_LONG_HOLD_MASK  8'h05
`define BFS_LATCH_MASK      8'h70
`define BFS_FAST_MASK       8'h01
`define BFS_CELL_CHEMISTRY_SELECT_MAX        4'd5

// register byte offsets
`define BFS_A_SHUNT_MAX     8'h00
`define BFS_A_CHG_TRIP      8'h04
`define BFS_A_DIS_TRIP      8'h08
`define BFS_A_CHG_NOM       8'h0c
`define BFS_A_DIS_NOM       8'h10
`define BFS_A_CELL_CHEMISTRY_SELECT          8'h14
`define BFS_A_STATUS        8'h18
`define BFS_A_INT_STAT      8'h1c
`define BFS_A_INT_MASK      8'h20

// reset values
`define BFS_RST_SHUNT_MAX   16'h2710
`define BFS_RST_CHG_TRIP    16'h1388
`define BFS_RST_DIS_TRIP    16'h1388
`define BFS_RST_CHG_NOM     16'h0fa0
`define BFS_RST_DIS_NOM     16'h0fa0
`define BFS_RST_CELL_CHEMISTRY_SELECT        4'h0
`define BFS_RST_INT_MASK    8'h00

`endif

/* bfs_pkg.sv */
// types shared by the battery fault supervisor files
package bfs_pkg;
    typedef logic        [15:0] bfs_cur_t;
    typedef logic signed [15:0] bfs_scur_t;
    typedef logic        [12:0] bfs_mv_t;
    typedef logic        [4:0]  bfs_code_t;

    typedef enum logic [1:0] {
        BFS_PH_POWERUP = 2'b00,
        BFS_PH_RUN     = 2'b01,
        BFS_PH_HALT    = 2'b10
    } bfs_phase_t;

    typedef enum logic [1:0] {
        BFS_BL_IDLE = 2'b00,
        BFS_BL_ON   = 2'b01,
        BFS_BL_OFF  = 2'b10,
        BFS_BL_GAP  = 2'b11
    } bfs_blink_t;
endpackage

/* bfs_blink.sv */
// error led blink sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bfs_cfg.svh"
module bfs_blink #(
    parameter int unsigned BLINK_CYC = `BFS_BLINK_CYC,
    parameter int unsigned GAP_CYC   = `BFS_GAP_CYC
) (
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // code to show, zero for none
    input  wire bfs_pkg::bfs_code_t code,
    // led drive
    output var  logic           led_q
);
    import bfs_pkg::*;

    bfs_blink_t  st_q;
    logic [31:0] cnt_q;
    bfs_code_t   left_q;

    // code latched per sequence, counts never cut short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= BFS_BL_IDLE;
            cnt_q  <= 32'h0;
            left_q <= 5'h0;
            led_q  <= 1'b0;
        end else begin
            unique case (st_q)
                BFS_BL_IDLE: begin
                    led_q <= 1'b0;
                    if (code != 5'h0) begin
                        left_q <= code;
                        cnt_q  <= 32'h0;
                        led_q  <= 1'b1;
                        st_q   <= BFS_BL_ON;
                    end
                end
                BFS_BL_ON: begin
                    if (cnt_q >= BLINK_CYC - 1) begin
                        cnt_q  <= 32'h0;
                        led_q  <= 1'b0;
                        left_q <= left_q - 5'h1;
                        st_q   <= (left_q == 5'h1) ? BFS_BL_GAP : BFS_BL_OFF;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                BFS_BL_OFF: begin
                    if (cnt_q >= BLINK_CYC - 1) begin
                        cnt_q <= 32'h0;
                        led_q <= 1'b1;
                        st_q  <= BFS_BL_ON;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                BFS_BL_GAP: begin
                    if (cnt_q >= GAP_CYC - 1) begin
                        cnt_q <= 32'h0;
                        st_q  <= BFS_BL_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
            endcase
        end
    end
endmodule // bfs_blink
`default_nettype wire

/* bfs_top_chk.sv */
// port checker, fault supervisor
`timescale 1ns/1ps
`default_nettype none
module bfs_chk #(
    parameter int unsigned MEAS_CYC  = 20,
    parameter int unsigned BLINK_CYC = 3
) (
    // clock, reset, bus answer
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               pready,
    input wire logic               pslverr,
    // pack inputs
    input wire bfs_pkg::bfs_mv_t   cell_v_max_mv,
    input wire bfs_pkg::bfs_mv_t   cell_v_min_mv,
    input wire bfs_pkg::bfs_scur_t pack_current,
    input wire logic               relay_open_cmd,
    input wire logic               current_meas_en,
    input wire logic               internal_bus_fail,
    // pack control and indication
    input wire logic               charge_en,
    input wire logic               discharge_en,
    input wire logic               opto_relay_on,
    input wire logic               charge_opto_on,
    input wire logic               settings_restore,
    input wire logic               error_led
);
    import bfs_pkg::*;
    // tick phase plus output register
    localparam int unsigned TRIP = 3 * MEAS_CYC + 3;
    logic [31:0] off_q, volt_q, bus_q, hi_q;
    logic        halt_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {off_q, volt_q, bus_q, hi_q} <= '0;
            halt_q <= 1'b0;
        end else begin
            off_q  <= (relay_open_cmd && pack_current[15] || !current_meas_en) ? off_q + 32'd1 : '0;
            volt_q <= (cell_v_max_mv > 13'd4500 || cell_v_min_mv < 13'd800) ? volt_q + 32'd1 : '0;
            bus_q  <= internal_bus_fail ? bus_q + 32'd1 : '0;
            hi_q   <= error_led ? hi_q + 32'd1 : '0;
            halt_q <= halt_q || bus_q >= TRIP;
        end
    end
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("no ready");
    property p_same_en; charge_en == discharge_en && discharge_en == opto_relay_on; endproperty
    a_same_en: assert property (p_same_en) else $error("enables disagree");
    property p_copto; $fell(charge_opto_on) |-> !opto_relay_on; endproperty
    a_copto: assert property (p_copto) else $error("opto alone");
    property p_cur_off; off_q >= TRIP |-> !charge_en; endproperty
    a_cur_off: assert property (p_cur_off) else $error("current fault on");
    property p_volt_off; volt_q >= TRIP |-> !charge_en && !discharge_en; endproperty
    a_volt_off: assert property (p_volt_off) else $error("cell fault on");
    property p_halt; halt_q |-> !charge_en && !charge_opto_on; endproperty
    a_halt: assert property (p_halt) else $error("left halt");
    property p_rest; settings_restore |=> !settings_restore; endproperty
    a_rest: assert property (p_rest) else $error("long restore");
    property p_blink; $fell(error_led) |-> hi_q == BLINK_CYC; endproperty
    a_blink: assert property (p_blink) else $error("blink width");
endmodule // bfs_chk
bind bfs_top bfs_chk #(.MEAS_CYC(MEAS_CYC), .BLINK_CYC(BLINK_CYC)) u_chk (.*);
`default_nettype wire

/* bfs_pack_model.sv */
// battery pack sensor model
`timescale 1ns/1ps
`default_nettype none
module bfs_pack (
    // clock and relay state
    input  wire logic               pclk,
    input  wire logic               opto_relay_on,
    // sensed pack values
    output var  bfs_pkg::bfs_mv_t   cell_v_max_mv,
    output var  bfs_pkg::bfs_mv_t   cell_v_min_mv,
    output var  bfs_pkg::bfs_scur_t pack_current,
    output var  logic               relay_open_cmd,
    output var  logic               current_meas_en
);
    import bfs_pkg::*;
    bfs_scur_t cur_s;
    initial begin
        cur_s = '0;
        {cell_v_max_mv, cell_v_min_mv} = {13'd3600, 13'd3300};
        {relay_open_cmd, current_meas_en} = 2'b01;
    end
    // no current unless relay closed or welded
    always @(posedge pclk) pack_current <= (opto_relay_on || relay_open_cmd) ? cur_s : '0;
    task automatic set(input int hi, input int lo, input int c, input logic ro, input logic me);
        {cell_v_max_mv, cell_v_min_mv, relay_open_cmd, current_meas_en} <= {13'(hi), 13'(lo), ro, me};
        cur_s <= 16'(c);
    endtask
endmodule // bfs_pack
`default_nettype wire

/* tb_top.sv */
// self-checking bench, fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bfs_pkg::*;
    localparam int M = 20;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, e, relay_open_cmd, current_meas_en, startup_active = 0, settings_io_broken = 0;
    logic startup_fuse_fault = 0, startup_balance_fault = 0, internal_bus_fail = 0;
    logic charge_en, discharge_en, opto_relay_on, charge_opto_on, settings_restore, error_led, irq;
    bfs_mv_t cell_v_max_mv, cell_v_min_mv;
    bfs_scur_t pack_current;
    bfs_cur_t chg_limit_report, dis_limit_report, nom;
    int n_errors = 0, n_compared = 0, cyc = 0, lo = 0, led_r = 0, led_n = 0, rest_n = 0, k, i;
    int cur4[4] = '{0, 5001, -5001, 4001};
    always #5 pclk = ~pclk;
    bfs_pack pk (.*);
    bfs_top #(.MEAS_CYC(M), .BLINK_CYC(3), .GAP_CYC(10)) DUT (.*);
    function automatic bfs_cur_t red(input bfs_cur_t n);
        return n - (n >> 2);
    endfunction
    task automatic results();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        {r, e} = {prdata, pslverr};
        if (n == 9) chk(0, 1);
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic wait_en(input logic v);
        int n;
        for (n = 0; charge_en !== v && n < 5 * M; n++) @(posedge pclk);
        chk(charge_en, v);
    endtask
    task automatic rst(input logic [3:0] cell_chemistry_select);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1, 8'h14, cell_chemistry_select);
    endtask
    // led burst count; hang guard
    always @(posedge pclk) begin
        if ($rose(error_led)) led_r <= led_r + 1;
        lo <= error_led ? 0 : lo + 1;
        if (lo == 5) {led_n, led_r} <= {led_r, 32'd0};
        if (settings_restore) rest_n <= rest_n + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        k = $urandom(11487);
        rst(4'h0);
        apb(0, 8'h40, 0);
        chk(e, 1);
        wait_en(0);
        chk(charge_opto_on, 0);
        apb(0, 8'h18, 0);
        chk(r[12:0], {5'd13, 8'h08});
        repeat (200) @(posedge pclk);
        chk(led_n, 13);
        chk(irq, 0);
        apb(1, 8'h20, 32'hff);
        @(posedge pclk) chk(irq, 1);
        apb(1, 8'h14, 1 + $urandom % 5);
        wait_en(1);
        apb(1, 8'h1c, 32'h08);
        @(posedge pclk) chk(irq, 0);
        for (k = 0; k < 2; k++) begin
            nom = 16'd1000 + 16'($urandom % 3000);
            apb(1, 8'h0c, nom);
            apb(1, 8'h10, nom);
            i = int'(nom) + int'(nom) / 5 + 1 + int'($urandom % 40);
            pk.set(3700, 3200, k ? -i : i, 0, 1);
            repeat (4 * M) @(posedge pclk);
            chk(chg_limit_report, red(nom));
            chk(dis_limit_report, red(nom));
            chk(opto_relay_on, 1);
            pk.set(3700, 3200, 0, 0, 1);
            repeat (2 * M) @(posedge pclk);
        end
        for (k = 0; k < 4; k++) begin
            if (k == 3) apb(1, 8'h00, 32'd2000);
            if (k == 3) apb(1, 8'h04, 32'h7fff);
            pk.set(3700, 3200, cur4[k], 0, k != 0);
            wait_en(0);
            pk.set(3700, 3200, 0, 0, 1);
            repeat (11 * M) @(posedge pclk);
            chk(charge_en, 0);
            repeat (2 * M) @(posedge pclk);
            chk(charge_en, 1);
        end
        pk.set(4501, 3200, -100, 1, 1);
        wait_en(0);
        apb(0, 8'h18, 0);
        chk(r[12:0], {5'd10, 8'h03});
        pk.set(4495, 3200, 0, 0, 1);
        repeat (14 * M) @(posedge pclk);
        apb(0, 8'h18, 0);
        chk({r[7:0], charge_en}, 9'h002);
        pk.set(3700, 3200, 0, 0, 1);
        repeat (13 * M) @(posedge pclk);
        chk(charge_en, 1);
        pk.set(3700, 799, 0, 0, 1);
        rst(4'h1);
        repeat (M - 1) @(posedge pclk);
        chk(charge_en, 0);
        pk.set(3700, 3200, 0, 0, 1);
        rst(4'h2);
        apb(1, 8'h0c, 32'h0123);
        {startup_active, settings_io_broken} <= 2'b11;
        repeat (4 * M) @(posedge pclk);
        chk(rest_n, 1);
        apb(0, 8'h0c, 0);
        chk({r, charge_en}, {32'h0fa0, 1'b1});
        settings_io_broken <= 1'b0;
        for (k = 0; k < 2; k++) begin
            rst(4'h3);
            {startup_fuse_fault, startup_balance_fault} <= k ? 2'b01 : 2'b10;
            wait_en(0);
            {startup_fuse_fault, startup_balance_fault} <= 2'b00;
            repeat (14 * M) @(posedge pclk);
            chk(charge_en, 0);
        end
        rst(4'h4);
        internal_bus_fail <= 1'b1;
        wait_en(0);
        internal_bus_fail <= 1'b0;
        repeat (2 * M) @(posedge pclk);
        apb(0, 8'h18, 0);
        chk({r[17:16], charge_en, charge_opto_on}, 4'b1000);
        results();
    end
endmodule // tb_top
`default_nettype wire
